// *** isc_pkg.sv ***
// Purpose: shared constants and types for interface select and sync control
// Assumes: APB with 32-bit data, byte address = 4 * register index
// Notes: indices below are register indices, not byte addresses
package isc_pkg;
	localparam int ADDR_W = 12;
	localparam int IDX_MSB = 9;
	localparam int IDX_LSB = 2;
	localparam logic [7:0] IDX_ICTL = 8'h0F;
	localparam logic [7:0] IDX_SCTL = 8'h10;
	localparam logic [7:0] IDX_PWR = 8'h14;
	localparam logic [7:0] IDX_STAT = 8'h15;
	localparam logic [7:0] IDX_XCFG = 8'h20;
	localparam logic [7:0] IDX_IST = 8'h21;
	localparam logic [7:0] IDX_IMSK = 8'h22;
	localparam int ICTL_THR_HI = 7;
	localparam int ICTL_THR_LO = 3;
	localparam int ICTL_OVR = 2;
	localparam int ICTL_CHO = 1;
	localparam int SCTL_LPOL = 6;
	localparam int SCTL_FPOL = 2;
	localparam int PWR_ON = 1;
	localparam int ST_LINE = 7;
	localparam int ST_EMB = 6;
	localparam int ST_FRM = 5;
	localparam int ST_DCLK = 4;
	localparam int ST_AACT = 3;
	localparam int ST_DACT = 2;
	localparam int ST_DDONE = 1;
	localparam int XCFG_W = 16;
	localparam int X_CSEL = 0;
	localparam int X_VSRC = 1;
	localparam int X_PH_LO = 4;
	localparam int X_HW_LO = 8;
	localparam int PH_W = 3;
	localparam int HW_W = 8;
	localparam int VS_W = 12;
	localparam int DE_W = 6;
	localparam int PIPE_N = 8;
	localparam int NEV = 2;
	localparam int EV_IFCHG = 0;
	localparam int EV_DDONE = 1;
	localparam int NSY = 8;
	localparam int SY_LINE = 0;
	localparam int SY_FRM = 1;
	localparam int SY_CMP = 2;
	localparam int SY_PL = 3;
	localparam int SY_PF = 4;
	localparam int SY_PE = 5;
	localparam int SY_DC = 6;
	localparam int SY_DE = 7;
	localparam logic [7:0] ICTL_RST = 8'h80;
	localparam logic [7:0] PWR_RST = 8'h02;
	localparam logic [15:0] XCFG_RST = 16'h0400;
	typedef enum logic [1:0] {IF_NONE = 2'b00, IF_ANA = 2'b01, IF_DIG = 2'b11} isc_if_t;
	typedef enum logic [1:0] {DE_SEEK = 2'b00, DE_CNT = 2'b01, DE_DONE = 2'b11} isc_de_t;
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} isc_rgb_t;
	typedef struct packed {
		logic     clk;
		logic     hs;
		isc_rgb_t rgb;
	} isc_pix_t;
	typedef struct packed {
		logic [NSY-1:0]          s1;
		logic [NSY-1:0]          s2;
		logic [NSY-1:0]          s3;
		logic [NSY-1:0]          flt;
		logic [7:0]              ictl;
		logic [7:0]              sctl;
		logic [7:0]              pwr;
		logic [XCFG_W-1:0]       xcfg;
		logic [NEV-1:0]          ist;
		logic [NEV-1:0]          imsk;
		logic                    ls_prev;
		logic                    ls_dly;
		logic                    pll_ref;
		logic                    clamp;
		logic [HW_W-1:0]         hs_cnt;
		logic                    hs_out;
		logic [VS_W-1:0]         vs_cnt;
		logic                    cs_out;
		logic                    fs_out;
		logic                    de_prev;
		logic [DE_W-1:0]         de_cnt;
		isc_de_t                 de_st;
		isc_if_t                 active;
		logic                    apd;
		logic                    dpd;
		logic                    pdiv;
		isc_pix_t [PIPE_N-1:0]   pipe;
		isc_pix_t                pout;
		logic [31:0]             prdata;
		logic                    cap;
	} isc_st_t;
endpackage

// *** isc_top.sv ***
// Purpose: sync routing, output alignment and active interface select
// Assumes: video samples and comparator come in on pclk; pins are async
// Notes: registers reached over APB, one word per register index
// How it works
// - line sync polarity bit picks falling (0) or rising (1) leading edge
// - leading edge feeds the clock generator, trailing edge times clamping
// - slicer threshold comes from control bits seven down to three
// - slicer result passes to composite output without inversion
// - composite output selects slicer result or delayed raw line sync
// - line sync out rebuilt, aligned; width programmable except when digital is active
// - output clock comes from internal divider, synchronous with sampling
// - phase setting moves data, clock and line sync together
// - frame sync out: separated or direct, polarity from a bit
// - each colour bus carries bit seven as its msb
// - override set: select bit forces analog (0) or digital (1)
// - auto, nothing detected: both sides powered down, none active
// - auto, only digital detected: digital active, analog down
// - auto, only analog detected: analog active, digital down
// - auto, both detected: select bit gives priority
// - analog detect is OR of three sync flags; digital is clock flag
// - digital clock seen: power up, count 32 valid windows, then done
// - power-down beats override, override beats auto detection
`timescale 1ns/10ps
module isc_top #(
	parameter logic [11:0] VSEP_CYCLES = 12'h200,
	parameter int          DE_NEEDED   = 32
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              line_sync_in,
	input  wire logic              frame_sync_in,
	input  wire logic              slicer_cmp_in,
	input  wire logic              pres_line,
	input  wire logic              pres_frame,
	input  wire logic              pres_emb,
	input  wire logic              dclk_present,
	input  wire logic              data_valid_window,
	input  isc_pkg::isc_rgb_t      video_in,
	output isc_pkg::isc_rgb_t      video_out,
	output logic [4:0]             slicer_threshold,
	output logic                   composite_sync_output,
	output logic                   line_sync_output,
	output logic                   frame_sync_output,
	output logic                   pixel_output_clock,
	output logic                   pll_ref_pulse,
	output logic                   clamp_ref_pulse,
	output logic                   analog_pd,
	output logic                   digital_pd,
	output isc_pkg::isc_if_t       active_if,
	output logic                   irq
);
	localparam logic [isc_pkg::DE_W-1:0] DE_LAST = isc_pkg::DE_W'(DE_NEEDED - 1);
	// line sync rests high under the reset polarity, so no false edge follows reset
	localparam logic [isc_pkg::NSY-1:0] SY_IDLE = isc_pkg::NSY'(1) << isc_pkg::SY_LINE;
	localparam isc_pkg::isc_st_t ST_RST = '{
		s1: SY_IDLE,
		s2: SY_IDLE,
		s3: SY_IDLE,
		flt: SY_IDLE,
		ictl: isc_pkg::ICTL_RST,
		pwr: isc_pkg::PWR_RST,
		xcfg: isc_pkg::XCFG_RST,
		de_st: isc_pkg::DE_SEEK,
		active: isc_pkg::IF_NONE,
		apd: 1'b1,
		dpd: 1'b1,
		default: '0
	};

	isc_pkg::isc_st_t          r;
	isc_pkg::isc_st_t          n;
	logic [7:0]                idx;
	logic                      addr_ok;
	logic                      acc;
	logic                      wr_en;
	logic                      rd_en;
	logic [31:0]               rmux;
	logic                      ls_n;
	logic                      lead;
	logic                      ana_det;
	logic                      dig_det;
	logic                      de_rise;
	logic                      vs_sep;
	logic [isc_pkg::NEV-1:0]   ev;
	logic [isc_pkg::PH_W-1:0]  phase;
	logic [isc_pkg::HW_W-1:0]  hw;
	isc_pkg::isc_pix_t         pix;

	assign idx = paddr[isc_pkg::IDX_MSB:isc_pkg::IDX_LSB];
	assign acc = psel & penable & r.cap;
	assign pready = ce & acc;
	assign wr_en = pready & pwrite & addr_ok;
	assign rd_en = pready & ~pwrite & addr_ok;
	assign pslverr = pready & ~addr_ok;

	always_comb
	begin
		addr_ok = (paddr[isc_pkg::ADDR_W-1:isc_pkg::IDX_MSB+1] == '0)
			&& (paddr[isc_pkg::IDX_LSB-1:0] == '0);
		case (idx)
			isc_pkg::IDX_ICTL, isc_pkg::IDX_SCTL, isc_pkg::IDX_PWR,
			isc_pkg::IDX_STAT, isc_pkg::IDX_XCFG, isc_pkg::IDX_IST,
			isc_pkg::IDX_IMSK: ;
			default: addr_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		rmux = '0;
		case (idx)
			isc_pkg::IDX_ICTL: rmux[7:0] = r.ictl;
			isc_pkg::IDX_SCTL: rmux[7:0] = r.sctl;
			isc_pkg::IDX_PWR: rmux[7:0] = r.pwr;
			isc_pkg::IDX_XCFG: rmux[isc_pkg::XCFG_W-1:0] = r.xcfg;
			isc_pkg::IDX_IST: rmux[isc_pkg::NEV-1:0] = r.ist;
			isc_pkg::IDX_IMSK: rmux[isc_pkg::NEV-1:0] = r.imsk;
			isc_pkg::IDX_STAT:
			begin
				rmux[isc_pkg::ST_LINE] = r.flt[isc_pkg::SY_PL];
				rmux[isc_pkg::ST_EMB] = r.flt[isc_pkg::SY_PE];
				rmux[isc_pkg::ST_FRM] = r.flt[isc_pkg::SY_PF];
				rmux[isc_pkg::ST_DCLK] = r.flt[isc_pkg::SY_DC];
				rmux[isc_pkg::ST_AACT] = r.active == isc_pkg::IF_ANA;
				rmux[isc_pkg::ST_DACT] = r.active == isc_pkg::IF_DIG;
				rmux[isc_pkg::ST_DDONE] = r.de_st == isc_pkg::DE_DONE;
			end
			default: rmux = '0;
		endcase
	end

	always_comb
	begin
		n = r;
		ev = '0;
		phase = r.xcfg[isc_pkg::X_PH_LO +: isc_pkg::PH_W];
		hw = r.xcfg[isc_pkg::X_HW_LO +: isc_pkg::HW_W];
		// three stages; a change counts once stages two and three agree
		n.s1 = {data_valid_window, dclk_present, pres_emb, pres_frame,
			pres_line, slicer_cmp_in, frame_sync_in, line_sync_in};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.flt = (r.s2 & r.s3) | (r.flt & (r.s2 ^ r.s3));

		// polarity bit makes the chosen edge the rising one of ls_n
		ls_n = r.flt[isc_pkg::SY_LINE] ~^ r.sctl[isc_pkg::SCTL_LPOL];
		lead = ls_n & ~r.ls_prev;
		n.ls_prev = ls_n;
		// leading edge to the clock generator, trailing edge to clamp
		n.pll_ref = lead;
		n.clamp = ~ls_n & r.ls_prev;

		// analog: fixed width from the leading edge; digital: follows input
		if (r.active == isc_pkg::IF_DIG)
			n.hs_out = ls_n;
		else if (lead)
		begin
			n.hs_out = 1'b1;
			n.hs_cnt = hw;
		end
		else if (r.hs_cnt != '0)
			n.hs_cnt = r.hs_cnt - isc_pkg::HW_W'(1);
		else
			n.hs_out = 1'b0;

		// slicer result is passed straight, never inverted
		n.ls_dly = r.flt[isc_pkg::SY_LINE];
		// only a select, no further processing on this path
		n.cs_out = r.xcfg[isc_pkg::X_CSEL] ? r.ls_dly : r.flt[isc_pkg::SY_CMP];

		// embedded sync is low going; a long low is the frame interval
		if (r.flt[isc_pkg::SY_CMP])
			n.vs_cnt = '0;
		else if (r.vs_cnt != VSEP_CYCLES)
			n.vs_cnt = r.vs_cnt + isc_pkg::VS_W'(1);
		vs_sep = r.vs_cnt == VSEP_CYCLES;
		// source select, then polarity: bit set keeps the sense
		n.fs_out = (r.xcfg[isc_pkg::X_VSRC] ? r.flt[isc_pkg::SY_FRM] : vs_sep)
			~^ r.sctl[isc_pkg::SCTL_FPOL];

		ana_det = r.flt[isc_pkg::SY_PL] | r.flt[isc_pkg::SY_PF] | r.flt[isc_pkg::SY_PE];
		dig_det = r.flt[isc_pkg::SY_DC];

		// power-down first, then override, then automatic
		if (!r.pwr[isc_pkg::PWR_ON])
			n.active = isc_pkg::IF_NONE;
		else if (r.ictl[isc_pkg::ICTL_OVR])
			n.active = r.ictl[isc_pkg::ICTL_CHO] ? isc_pkg::IF_DIG : isc_pkg::IF_ANA;
		else if (ana_det && dig_det)
			n.active = r.ictl[isc_pkg::ICTL_CHO] ? isc_pkg::IF_DIG : isc_pkg::IF_ANA;
		else if (dig_det)
			n.active = isc_pkg::IF_DIG;
		else if (ana_det)
			n.active = isc_pkg::IF_ANA;
		else
			n.active = isc_pkg::IF_NONE;
		ev[isc_pkg::EV_IFCHG] = n.active != r.active;

		// second stage: count valid windows while the clock is present
		de_rise = r.flt[isc_pkg::SY_DE] & ~r.de_prev;
		n.de_prev = r.flt[isc_pkg::SY_DE];
		case (r.de_st)
			isc_pkg::DE_SEEK:
			begin
				n.de_cnt = '0;
				if (dig_det && r.pwr[isc_pkg::PWR_ON])
					n.de_st = isc_pkg::DE_CNT;
			end
			isc_pkg::DE_CNT:
			begin
				if (!dig_det || !r.pwr[isc_pkg::PWR_ON])
					n.de_st = isc_pkg::DE_SEEK;
				else if (de_rise && r.de_cnt == DE_LAST)
				begin
					n.de_st = isc_pkg::DE_DONE;
					ev[isc_pkg::EV_DDONE] = 1'b1;
				end
				else if (de_rise)
					n.de_cnt = r.de_cnt + isc_pkg::DE_W'(1);
			end
			isc_pkg::DE_DONE:
			begin
				if (!dig_det || !r.pwr[isc_pkg::PWR_ON])
					n.de_st = isc_pkg::DE_SEEK;
			end
			default: n.de_st = isc_pkg::DE_SEEK;
		endcase

		// digital side stays up during its search so windows can be counted
		n.apd = n.active != isc_pkg::IF_ANA;
		n.dpd = !(n.active == isc_pkg::IF_DIG || n.de_st == isc_pkg::DE_CNT);

		// output clock is the sampling clock, half of pclk
		n.pdiv = ~r.pdiv;
		pix.clk = ~r.pdiv;
		pix.hs = r.hs_out;
		pix.rgb = r.pdiv ? r.pipe[0].rgb : video_in;
		// one delay line for clock, sync and data keeps them in step
		n.pipe = {r.pipe[isc_pkg::PIPE_N-2:0], pix};
		n.pout = r.pipe[phase];

		// APB: read data is captured in setup, answered one cycle later
		n.cap = psel & ~acc;
		if (psel && !r.cap)
			n.prdata = rmux;
		if (wr_en)
		begin
			case (idx)
				isc_pkg::IDX_ICTL: n.ictl = pwdata[7:0];
				isc_pkg::IDX_SCTL: n.sctl = pwdata[7:0];
				isc_pkg::IDX_PWR: n.pwr = pwdata[7:0];
				isc_pkg::IDX_XCFG: n.xcfg = pwdata[isc_pkg::XCFG_W-1:0];
				isc_pkg::IDX_IMSK: n.imsk = pwdata[isc_pkg::NEV-1:0];
				default: ;
			endcase
		end
		// read clears only what the setup capture returned; an event that lands
		// between setup and access, or in the access cycle, survives
		if (rd_en && idx == isc_pkg::IDX_IST)
			n.ist = (r.ist & ~r.prdata[isc_pkg::NEV-1:0]) | ev;
		else
			n.ist = r.ist | ev;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= ST_RST;
		else if (ce)
			r <= n;
	end

	assign prdata = r.prdata;
	// threshold field drives the comparator reference
	assign slicer_threshold = r.ictl[isc_pkg::ICTL_THR_HI:isc_pkg::ICTL_THR_LO];
	assign composite_sync_output = r.cs_out;
	assign frame_sync_output = r.fs_out;
	assign line_sync_output = r.pout.hs;
	assign pixel_output_clock = r.pout.clk;
	// fields are [7:0], bit seven the msb
	assign video_out = r.pout.rgb;
	assign pll_ref_pulse = r.pll_ref;
	assign clamp_ref_pulse = r.clamp;
	assign analog_pd = r.apd;
	assign digital_pd = r.dpd;
	assign active_if = r.active;
	assign irq = |(r.ist & r.imsk);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_lead_edge: assert property (
		$past(ce) && r.pll_ref |-> $past(ls_n) && !$past(r.ls_prev))
		else $error("leading edge pulse without active edge");
	chk_clamp_edge: assert property (
		$past(ce) && r.clamp |-> !$past(ls_n) && $past(r.ls_prev))
		else $error("clamp pulse without trailing edge");
	chk_thr_write: assert property (
		ce && wr_en && idx == isc_pkg::IDX_ICTL |=>
		slicer_threshold == $past(pwdata[isc_pkg::ICTL_THR_HI:isc_pkg::ICTL_THR_LO]))
		else $error("threshold not taken from write");
	chk_cs_route: assert property (
		$past(ce) && !$past(r.xcfg[isc_pkg::X_CSEL]) |->
		composite_sync_output == $past(r.flt[isc_pkg::SY_CMP]))
		else $error("composite output not the slicer result");
	chk_override_sel: assert property (
		$past(ce) && $past(r.pwr[isc_pkg::PWR_ON] && r.ictl[isc_pkg::ICTL_OVR]) |->
		active_if == ($past(r.ictl[isc_pkg::ICTL_CHO]) ? isc_pkg::IF_DIG : isc_pkg::IF_ANA))
		else $error("override did not force interface");
	chk_none_down: assert property (
		active_if == isc_pkg::IF_NONE |-> analog_pd && digital_pd)
		else $error("side powered with no active interface");
	chk_dig_only: assert property (
		$past(ce) && $past(r.pwr[isc_pkg::PWR_ON] && !r.ictl[isc_pkg::ICTL_OVR]
		&& dig_det && !ana_det) |-> active_if == isc_pkg::IF_DIG && analog_pd)
		else $error("digital only detection not honoured");
	chk_pd_first: assert property (
		$past(ce) && !$past(r.pwr[isc_pkg::PWR_ON]) |-> active_if == isc_pkg::IF_NONE)
		else $error("power-down did not win");
	chk_de_count: assert property (
		$past(ce) && r.de_st == isc_pkg::DE_DONE && $past(r.de_st) == isc_pkg::DE_CNT
		|-> $past(r.de_cnt) == DE_LAST && $past(de_rise))
		else $error("detection done before full window count");
	chk_cs_delayed: assert property (
		$past(ce) && $past(ce, 2) && $past(r.xcfg[isc_pkg::X_CSEL]) |->
		composite_sync_output == $past(r.flt[isc_pkg::SY_LINE], 2))
		else $error("composite output not the delayed line sync");
	chk_fs_direct: assert property (
		$past(ce) && $past(r.xcfg[isc_pkg::X_VSRC]) |-> frame_sync_output ==
		($past(r.sctl[isc_pkg::SCTL_FPOL]) ? $past(r.flt[isc_pkg::SY_FRM])
		: !$past(r.flt[isc_pkg::SY_FRM])))
		else $error("frame output not the direct input in its polarity");
	chk_none_auto: assert property (
		$past(ce) && $past(r.pwr[isc_pkg::PWR_ON] && !r.ictl[isc_pkg::ICTL_OVR]
		&& !dig_det && !ana_det) |-> active_if == isc_pkg::IF_NONE)
		else $error("interface active with nothing detected");
	chk_ana_only: assert property (
		$past(ce) && $past(r.pwr[isc_pkg::PWR_ON] && !r.ictl[isc_pkg::ICTL_OVR]
		&& ana_det && !dig_det) |-> active_if == isc_pkg::IF_ANA && digital_pd)
		else $error("analog only detection not honoured");
	chk_both_sel: assert property (
		$past(ce) && $past(r.pwr[isc_pkg::PWR_ON] && !r.ictl[isc_pkg::ICTL_OVR]
		&& ana_det && dig_det) |->
		active_if == ($past(r.ictl[isc_pkg::ICTL_CHO]) ? isc_pkg::IF_DIG : isc_pkg::IF_ANA))
		else $error("select bit did not decide between detected sides");
	chk_hs_width: assert property (
		ce && lead && r.active != isc_pkg::IF_DIG |=> r.hs_out && r.hs_cnt == $past(hw))
		else $error("line sync pulse not started at programmed width");
	chk_flt_agree: assert property (
		ce |=> ((r.flt ^ $past(r.flt)) & ($past(r.s2) ^ $past(r.s3))) == '0)
		else $error("filtered flag moved while stages disagree");
	chk_search_pwr: assert property (
		r.de_st == isc_pkg::DE_CNT |-> !digital_pd)
		else $error("digital side down during window search");
	chk_ev_sticky: assert property (
		ce && ev[isc_pkg::EV_IFCHG] |=> r.ist[isc_pkg::EV_IFCHG])
		else $error("interface change event lost");
endmodule // isc_top

// *** isc_src.sv ***
// Purpose: graphics source model driving sync pins, presence flags and video
// Assumes: every change is made by non-blocking assignment just after pclk rises
// Notes: video steps every cycle so a stuck data path cannot pass unseen
`timescale 1ns/10ps
module isc_src (
	input  wire logic         clk,
	output logic              line,
	output logic              frame,
	output logic              cmp,
	output logic [3:0]        flags,
	output logic              dv,
	output isc_pkg::isc_rgb_t vid
);
	initial
	begin
		{frame, cmp, flags, dv} = '0;
		// line rests high, the idle level for the reset polarity
		line = 1'b1;
		vid = '0;
	end
	always @(posedge clk)
		vid <= vid + 24'h01_0101;
	task automatic pins(input logic l, input logic f, input logic c);
		@(posedge clk);
		line <= l;
		frame <= f;
		cmp <= c;
	endtask
	// flags order: line, frame, embedded, digital clock
	task automatic pres(input logic [3:0] p);
		@(posedge clk);
		flags <= p;
	endtask
	// windows long enough to survive the receiver's glitch filter
	task automatic windows(input int n);
		repeat (n)
		begin
			@(posedge clk);
			dv <= 1'b1;
			repeat (4) @(posedge clk);
			dv <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
endmodule // isc_src

// *** tb.sv ***
// Purpose: self-checking bench for interface select and sync control
// Assumes: APB byte address is four times the register index
// Notes: detection count shortened to 4 windows; clock enable dropped once
`timescale 1ns/10ps
module tb;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              ln;
	logic              fr;
	logic              cm;
	logic [3:0]        fl;
	logic              dv;
	isc_pkg::isc_rgb_t vin;
	isc_pkg::isc_rgb_t vout;
	logic [4:0]        thr;
	logic              cs_o;
	logic              ls_o;
	logic              fs_o;
	logic              pll;
	logic              clp;
	logic              apd;
	logic              dpd;
	isc_pkg::isc_if_t  act;
	logic              irq;
	logic              ce;
	logic              pclk_o;
	logic [31:0]       rd;
	logic              er;
	int                mismatches;
	int                num_checks;
	int                npll;
	int                ncl;
	int                nhs;
	isc_top #(.VSEP_CYCLES(12'h008), .DE_NEEDED(4)) dut (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_sync_in(ln), .frame_sync_in(fr), .slicer_cmp_in(cm), .pres_line(fl[3]),
		.pres_frame(fl[2]), .pres_emb(fl[1]), .dclk_present(fl[0]),
		.data_valid_window(dv), .video_in(vin), .video_out(vout),
		.slicer_threshold(thr), .composite_sync_output(cs_o), .line_sync_output(ls_o),
		.frame_sync_output(fs_o), .pixel_output_clock(pclk_o), .pll_ref_pulse(pll),
		.clamp_ref_pulse(clp), .analog_pd(apd), .digital_pd(dpd), .active_if(act),
		.irq(irq));
	isc_src src (.clk(pclk), .line(ln), .frame(fr), .cmp(cm), .flags(fl), .dv(dv),
		.vid(vin));
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// counted on the falling edge so reads after a rising edge never race
	always @(negedge pclk)
	begin
		npll += (pll === 1'b1);
		ncl += (clp === 1'b1);
		nhs += (ls_o === 1'b1);
	end
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			mismatches++;
			conclude();
		end
	endtask
	task automatic t_reset();
		chk(thr, 5'h10);
		chk({apd, dpd, act}, 4'b1100);
		apb(1'b0, 12'h03C, 32'h0);
		chk(rd, 32'h0000_0080);
		apb(1'b0, 12'h050, 32'h0);
		chk(rd, 32'h0000_0002);
		apb(1'b0, 12'h080, 32'h0);
		chk(rd, 32'h0000_0400);
		apb(1'b1, 12'h004, 32'h0000_FFFF);
		chk(er, 1'b1);
		apb(1'b1, 12'h03C, 32'h0000_0058);
		repeat (2) @(posedge pclk);
		chk(thr, 5'h0B);
		$display("test reset done");
	endtask
	task automatic t_select();
		isc_pkg::isc_if_t e;
		logic ana;
		for (int i = 0; i < 64; i++)
		begin
			src.pres(i[3:0]);
			apb(1'b1, 12'h03C, {29'h0, i[5:4], 1'b0} | 32'h0000_0080);
			repeat (8) @(posedge pclk);
			ana = |i[3:1];
			e = (i[5] || (ana && i[0])) ? (i[4] ? isc_pkg::IF_DIG : isc_pkg::IF_ANA) :
				i[0] ? isc_pkg::IF_DIG : ana ? isc_pkg::IF_ANA : isc_pkg::IF_NONE;
			chk(act, e);
			if (!i[5])
				chk(apd, e != isc_pkg::IF_ANA);
			if (!i[5] && !i[0])
				chk(dpd, 1'b1);
			apb(1'b0, 12'h054, 32'h0);
			chk(rd[7:4], {i[3], i[1], i[2], i[0]});
		end
		$display("test select done");
	endtask
	task automatic t_power();
		src.pres(4'hF);
		apb(1'b1, 12'h03C, 32'h0000_0084);
		apb(1'b1, 12'h050, 32'h0);
		repeat (8) @(posedge pclk);
		chk({apd, dpd}, 2'b11);
		apb(1'b1, 12'h050, 32'h0000_0002);
		repeat (8) @(posedge pclk);
		chk(act, isc_pkg::IF_ANA);
		$display("test power done");
	endtask
	task automatic t_irq();
		apb(1'b1, 12'h088, 32'h0);
		src.pres(4'h1);
		apb(1'b1, 12'h03C, 32'h0000_0080);
		repeat (10) @(posedge pclk);
		apb(1'b0, 12'h084, 32'h0);
		src.pres(4'h8);
		repeat (10) @(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, 12'h088, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, 12'h084, 32'h0);
		chk(rd[0], 1'b1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		$display("test irq done");
	endtask
	task automatic t_ddone();
		src.pres(4'h1);
		repeat (10) @(posedge pclk);
		src.windows(3);
		apb(1'b0, 12'h054, 32'h0);
		chk(rd[1], 1'b0);
		src.windows(1);
		apb(1'b0, 12'h054, 32'h0);
		chk(rd[1], 1'b1);
		apb(1'b0, 12'h084, 32'h0);
		chk(rd[1:0], 2'b11);
		$display("test detect done");
	endtask
	task automatic t_sync();
		int a;
		int b;
		int h;
		src.pres(4'h8);
		apb(1'b1, 12'h080, 32'h0000_0500);
		for (int p = 0; p < 2; p++)
		begin
			apb(1'b1, 12'h040, {25'h0, p[0], 6'h04});
			src.pins(!p[0], 1'b0, 1'b0);
			repeat (12) @(posedge pclk);
			a = npll;
			b = ncl;
			h = nhs;
			src.pins(p[0], 1'b0, 1'b0);
			repeat (20) @(posedge pclk);
			chk(npll - a, 1);
			chk(ncl - b, 0);
			chk(nhs - h, 6);
			src.pins(!p[0], 1'b0, 1'b0);
			repeat (12) @(posedge pclk);
			chk(ncl - b, 1);
			chk(npll - a, 1);
		end
		$display("test sync done");
	endtask
	task automatic t_route();
		for (int v = 0; v < 2; v++)
		begin
			src.pins(v[0], v[0], !v[0]);
			apb(1'b1, 12'h080, 32'h0000_0402);
			apb(1'b1, 12'h040, 32'h0000_0004);
			repeat (8) @(posedge pclk);
			chk(cs_o, !v[0]);
			chk(fs_o, v[0]);
			apb(1'b1, 12'h080, 32'h0000_0403);
			apb(1'b1, 12'h040, 32'h0);
			repeat (8) @(posedge pclk);
			chk(cs_o, v[0]);
			chk(fs_o, !v[0]);
			apb(1'b1, 12'h080, 32'h0000_0400);
			apb(1'b1, 12'h040, 32'h0000_0004);
			repeat (12) @(posedge pclk);
			chk(fs_o, v[0]);
			chk(cs_o, !v[0]);
		end
		$display("test route done");
	endtask
	task automatic t_phase();
		int d [2];
		logic [23:0] v0;
		logic c;
		for (int k = 0; k < 2; k++)
		begin
			apb(1'b1, 12'h080, 32'h0000_0500 | (k * 32'h0000_0030));
			repeat (4) @(posedge pclk);
			src.pins(1'b0, 1'b1, 1'b0);
			d[k] = 0;
			while (ls_o !== 1'b1 && d[k] < 40)
			begin
				@(posedge pclk);
				d[k]++;
			end
			if (d[k] >= 40)
			begin
				mismatches++;
				conclude();
			end
			c = pclk_o;
			v0 = vout;
			repeat (2) @(posedge pclk);
			v0 = vout - v0;
			chk(pclk_o, c);
			chk(v0, 24'h02_0202);
			@(posedge pclk);
			chk(pclk_o, !c);
			src.pins(1'b1, 1'b1, 1'b0);
			repeat (20) @(posedge pclk);
		end
		chk(d[1] - d[0], 3);
		$display("test phase done");
	endtask
	task automatic t_hold();
		logic c;
		@(posedge pclk);
		ce <= 1'b0;
		src.pres(4'h1);
		repeat (10) @(posedge pclk);
		c = pclk_o;
		@(posedge pclk);
		chk(pclk_o, c);
		chk(act, isc_pkg::IF_ANA);
		ce <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(act, isc_pkg::IF_DIG);
		$display("test hold done");
	endtask
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ce = 1'b1;
		{mismatches, num_checks, npll, ncl, nhs} = '0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_select();
		t_power();
		t_irq();
		t_ddone();
		t_sync();
		t_route();
		t_phase();
		t_hold();
		conclude();
	end
endmodule // tb
